//--- inc/cacu_pkg.sv
/*
  Package for the cell converter correction unit: register map, field
  layout, reset values and timing counts.
  Assumes a 20 MHz system clock and an AXI4-Lite register bus.
*/
package cacu_pkg;

  localparam int          CLK_HZ        = 20_000_000;
  localparam int          PARK_DELAY_US = 100;
  localparam int          PARK_DELAY_CYC = (PARK_DELAY_US * (CLK_HZ / 1_000_000));

  localparam int          NUM_CELLS     = 16;
  localparam int          NUM_AUX       = 8;
  localparam int          RES_W         = 16;

  // Register byte addresses
  localparam logic [7:0]  ADDR_CELL_GAIN   = 8'h00;
  localparam logic [7:0]  ADDR_CELL_OFFSET = 8'h04;
  localparam logic [7:0]  ADDR_DEVICE_CONTROL_REG    = 8'h08;
  localparam logic [7:0]  ADDR_KEY_ONE     = 8'h0C;
  localparam logic [7:0]  ADDR_KEY_TWO     = 8'h10;
  localparam logic [7:0]  ADDR_CHAN_EN     = 8'h14;
  localparam logic [7:0]  ADDR_STATUS      = 8'h18;
  localparam logic [7:0]  ADDR_AUX_BASE    = 8'h20;

  // Control register fields
  localparam int          CTRL_PARK_BIT  = 0;
  localparam int          CTRL_NVWR_BIT  = 1;

  // Status register fields
  localparam int          STAT_PARK_ACT  = 0;
  localparam int          STAT_NV_BUSY   = 1;
  localparam int          STAT_MUX_LSB   = 4;

  localparam logic [15:0] KEY_ONE_VALUE  = 16'hA5A5;
  localparam logic [15:0] KEY_TWO_VALUE  = 16'h5A5A;
  localparam logic [15:0] CHAN_EN_RESET  = 16'hFFFF;

  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef enum {CACU_IDLE, CACU_DELAY, CACU_CONVERT} cacu_state_e;

endpackage

//--- src/cacu_top.sv
/*
  Cell converter correction unit: mux parking, pre-sampling delay, user
  trims on cell and auxiliary results, nonvolatile save request, and an
  AXI4-Lite register slave.
  Assumes the converter core delivers raw results already corrected by the
  factory trims, one valid pulse per result, and that the nonvolatile store
  answers a save request with a done pulse.
*/
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module cacu_top
  import cacu_pkg::*;
#(
  parameter int PARK_CYCLES = PARK_DELAY_CYC
)
(
  input  wire logic              CLK,
  input  wire logic              RST_N,
  // AXI4-Lite slave
  input  wire logic [7:0]        S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [7:0]        S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  // Converter side
  input  wire logic              SAMPLE_REQ,
  input  wire logic              SAMPLE_DONE,
  output logic                   SAMPLE_START,
  output logic [3:0]             MUX_SEL,
  input  wire logic              RAW_VALID,
  input  wire logic              RAW_IS_AUX,
  input  wire logic [3:0]        RAW_CHAN,
  input  wire logic [15:0]       RAW_DATA,
  output logic                   RES_VALID,
  output logic                   RES_IS_AUX,
  output logic [3:0]             RES_CHAN,
  output logic [15:0]            RES_DATA,
  // Nonvolatile store
  output logic                   NV_SAVE,
  input  wire logic              NV_DONE
);

  if (PARK_CYCLES < 1)
    $error("PARK_CYCLES must be at least one");

  localparam int CW = $clog2(PARK_CYCLES + 1);

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              aw_got;
    logic              w_got;
    logic [7:0]        aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [7:0]        cell_gain_trim;
    logic [7:0]        cell_offset_trim;
    logic [NUM_AUX-1:0][15:0] aux_channel_offset_trim;
    logic [15:0]       unlock_key_one;
    logic [15:0]       unlock_key_two;
    logic [15:0]       chan_en;
    logic              parking_control_bit;
    logic              park_active;
    logic              nv_busy;
    logic              nv_save;
    cacu_state_e       state;
    logic [CW-1:0]     cnt;
    logic              sample_start;
    logic [3:0]        mux_sel;
    logic              res_valid;
    logic              res_is_aux;
    logic [3:0]        res_chan;
    logic [15:0]       res_data;
  } cacu_state_s;

  cacu_state_s st;
  cacu_state_s next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [3:0] highest_enabled(input logic [15:0] en);
    logic [3:0] idx;
    idx = 4'hF;
    for (int i = 0; i < NUM_CELLS; i++)
      if (en[i])
        idx = 4'(i);
    return idx;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    logic [15:0] r;
    r = old;
    if (s[0])
      r[7:0] = d[7:0];
    if (s[1])
      r[15:8] = d[15:8];
    return r;
  endfunction

  // Clamp to unsigned 16-bit range instead of wrapping
  function automatic logic [15:0] clamp16(input logic signed [19:0] v);
    logic [15:0] r;
    if (v < 0)
      r = 16'h0000;
    else if (v > 20'sh0FFFF)
      r = 16'hFFFF;
    else
      r = v[15:0];
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Correction datapath and next state

  logic signed [25:0] gain_prod;
  logic signed [19:0] cell_sum;
  logic signed [19:0] aux_sum;
  logic [15:0]        aux_reg;
  logic               wr_fire;
  logic               rd_fire;
  logic [31:0]        rd_val;
  logic               rd_ok;
  logic               wr_ok;
  logic [15:0]        wv;
  logic               keys_ok;

  always_comb
  begin
    // Scaled by input/full-scale: trim * raw / 2^16
    gain_prod = $signed(st.cell_gain_trim) * $signed({1'b0, RAW_DATA});
    cell_sum  = $signed({4'h0, RAW_DATA})
              + 20'(gain_prod >>> 16)
              + 20'($signed(st.cell_offset_trim));
    aux_reg   = st.aux_channel_offset_trim[RAW_CHAN[2:0]];
    aux_sum   = $signed({4'h0, RAW_DATA})
              + 20'($signed(aux_reg[9:0]));
    next_st = st;
    wv      = '0;
    wr_ok   = 1'b0;
    rd_ok   = 1'b1;
    rd_val  = '0;
    keys_ok = (st.unlock_key_one == KEY_ONE_VALUE) && (st.unlock_key_two == KEY_TWO_VALUE);

    // Write channel: address and data may come in either order
    if (S_AXI_AWVALID && st.awready)
    begin
      next_st.aw_got  = 1'b1;
      next_st.aw_addr = S_AXI_AWADDR;
      next_st.awready = 1'b0;
    end
    if (S_AXI_WVALID && st.wready)
    begin
      next_st.w_got  = 1'b1;
      next_st.w_data = S_AXI_WDATA;
      next_st.w_strb = S_AXI_WSTRB;
      next_st.wready = 1'b0;
    end
    wr_fire = st.aw_got && st.w_got && !st.bvalid;
    if (wr_fire)
    begin
      wr_ok = 1'b1;
      if (st.aw_addr[7:5] == ADDR_AUX_BASE[7:5] && st.aw_addr[1:0] == 2'h0)
      begin
        wv = merge16(st.aux_channel_offset_trim[st.aw_addr[4:2]], st.w_data, st.w_strb);
        next_st.aux_channel_offset_trim[st.aw_addr[4:2]] = wv;
      end
      else
        unique case (st.aw_addr)
          ADDR_CELL_GAIN:
            if (st.w_strb[0])
              next_st.cell_gain_trim = st.w_data[7:0];
          ADDR_CELL_OFFSET:
            if (st.w_strb[0])
              next_st.cell_offset_trim = st.w_data[7:0];
          ADDR_KEY_ONE:
            next_st.unlock_key_one = merge16(st.unlock_key_one, st.w_data, st.w_strb);
          ADDR_KEY_TWO:
            next_st.unlock_key_two = merge16(st.unlock_key_two, st.w_data, st.w_strb);
          ADDR_CHAN_EN:
            next_st.chan_en = merge16(st.chan_en, st.w_data, st.w_strb);
          ADDR_DEVICE_CONTROL_REG:
            if (st.w_strb[0])
            begin
              next_st.parking_control_bit = st.w_data[CTRL_PARK_BIT];
              // Save only with both keys loaded; keys are consumed
              if (st.w_data[CTRL_NVWR_BIT] && keys_ok && !st.nv_busy)
              begin
                next_st.nv_busy        = 1'b1;
                next_st.nv_save        = 1'b1;
                next_st.unlock_key_one = '0;
                next_st.unlock_key_two = '0;
              end
            end
          ADDR_STATUS: ;
          default:
            wr_ok = 1'b0;
        endcase
      next_st.bvalid = 1'b1;
      next_st.bresp  = wr_ok ? RESP_OKAY : RESP_SLVERR;
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
    end
    if (st.bvalid && S_AXI_BREADY)
    begin
      next_st.bvalid  = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready  = 1'b1;
    end

    // Read channel
    rd_fire = S_AXI_ARVALID && st.arready;
    if (S_AXI_ARADDR[7:5] == ADDR_AUX_BASE[7:5] && S_AXI_ARADDR[1:0] == 2'h0)
      rd_val = {16'h0000, st.aux_channel_offset_trim[S_AXI_ARADDR[4:2]]};
    else
      unique case (S_AXI_ARADDR)
        ADDR_CELL_GAIN:   rd_val = {24'h000000, st.cell_gain_trim};
        ADDR_CELL_OFFSET: rd_val = {24'h000000, st.cell_offset_trim};
        ADDR_DEVICE_CONTROL_REG:    rd_val = {31'h00000000, st.parking_control_bit};
        ADDR_KEY_ONE:     rd_val = {16'h0000, st.unlock_key_one};
        ADDR_KEY_TWO:     rd_val = {16'h0000, st.unlock_key_two};
        ADDR_CHAN_EN:     rd_val = {16'h0000, st.chan_en};
        ADDR_STATUS:
        begin
          rd_val[STAT_PARK_ACT]              = st.park_active;
          rd_val[STAT_NV_BUSY]               = st.nv_busy;
          rd_val[STAT_MUX_LSB+3:STAT_MUX_LSB] = st.mux_sel;
        end
        default:          rd_ok = 1'b0;
      endcase
    if (rd_fire)
    begin
      next_st.arready = 1'b0;
      next_st.rvalid  = 1'b1;
      next_st.rdata   = rd_val;
      next_st.rresp   = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (st.rvalid && S_AXI_RREADY)
    begin
      next_st.rvalid  = 1'b0;
      next_st.arready = 1'b1;
    end

    // Nonvolatile save handshake
    next_st.nv_save = next_st.nv_save && !st.nv_save;
    if (st.nv_busy && NV_DONE)
      next_st.nv_busy = 1'b0;

    // Sampling sequencer
    next_st.sample_start = 1'b0;
    unique case (st.state)
      CACU_IDLE:
      begin
        next_st.mux_sel = highest_enabled(st.chan_en);
        if (SAMPLE_REQ)
        begin
          if (st.park_active)
          begin
            next_st.state = CACU_DELAY;
            next_st.cnt   = CW'(PARK_CYCLES - 1);
          end
          else
          begin
            next_st.state        = CACU_CONVERT;
            next_st.sample_start = 1'b1;
          end
        end
      end
      CACU_DELAY:
        if (st.cnt == '0)
        begin
          next_st.state        = CACU_CONVERT;
          next_st.sample_start = 1'b1;
        end
        else
          next_st.cnt = st.cnt - 1'b1;
      CACU_CONVERT:
        if (SAMPLE_DONE)
          next_st.state = CACU_IDLE;
    endcase

    // Parking setting latches only once a sample completes
    if (SAMPLE_DONE)
      next_st.park_active = st.parking_control_bit;

    // Result output
    next_st.res_valid  = RAW_VALID;
    next_st.res_is_aux = RAW_IS_AUX;
    next_st.res_chan   = RAW_CHAN;
    if (RAW_VALID)
      next_st.res_data = RAW_IS_AUX ? clamp16(aux_sum) : clamp16(cell_sum);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      st         <= '0;
      st.awready <= 1'b1;
      st.wready  <= 1'b1;
      st.arready <= 1'b1;
      st.chan_en <= CHAN_EN_RESET;
      st.mux_sel <= 4'hF;
      st.state   <= CACU_IDLE;
    end
    else
      st <= next_st;
  end

  assign S_AXI_AWREADY = st.awready;
  assign S_AXI_WREADY  = st.wready;
  assign S_AXI_BVALID  = st.bvalid;
  assign S_AXI_BRESP   = st.bresp;
  assign S_AXI_ARREADY = st.arready;
  assign S_AXI_RVALID  = st.rvalid;
  assign S_AXI_RDATA   = st.rdata;
  assign S_AXI_RRESP   = st.rresp;
  assign SAMPLE_START  = st.sample_start;
  assign MUX_SEL       = st.mux_sel;
  assign RES_VALID     = st.res_valid;
  assign RES_IS_AUX    = st.res_is_aux;
  assign RES_CHAN      = st.res_chan;
  assign RES_DATA      = st.res_data;
  assign NV_SAVE       = st.nv_save;

endmodule

//--- bench/cacu_top_properties.sv
/*
  Port-level checker for cacu_top.
  Bound from the bench top file; sees top ports only.
*/
`timescale 1ns/1ps
module cacu_props
(
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        RAW_VALID,
  input wire logic        RAW_IS_AUX,
  input wire logic [3:0]  RAW_CHAN,
  input wire logic        RES_VALID,
  input wire logic        RES_IS_AUX,
  input wire logic [3:0]  RES_CHAN,
  input wire logic        SAMPLE_START,
  input wire logic        NV_SAVE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  res_follow_a: assert property (RAW_VALID |=> RES_VALID)
    else $error("result pulse missing");
  res_quiet_a: assert property (!RAW_VALID |=> !RES_VALID)
    else $error("result pulse without raw input");
  res_route_a: assert property (RAW_VALID |=> RES_IS_AUX == $past(RAW_IS_AUX)
    && RES_CHAN == $past(RAW_CHAN)) else $error("result channel mismatch");
  start_pulse_a: assert property (SAMPLE_START |=> !SAMPLE_START)
    else $error("sample start wider than one cycle");
  save_pulse_a: assert property (NV_SAVE |=> !NV_SAVE)
    else $error("save pulse wider than one cycle");
  bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY
    |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped");
  rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY
    |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
  wr_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
    && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID) else $error("write not answered");
  rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read not answered");
  cover property (RES_VALID && RES_IS_AUX);
  cover property (SAMPLE_START);
  cover property (NV_SAVE);
endmodule

//--- bench/cacu_top_bench.sv
/*
  Self-checking bench for cacu_top: register access, result trims,
  mux parking, sampling delay and save request.
  Assumes cacu_pkg and the checker file are compiled first.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e); end end
module cacu_top_bench
  import cacu_pkg::*;
;
  // Short park count keeps the run brief
  localparam int PARK = 5;
  logic        clk = 0, rst_n = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic        req = 0, done = 0, rawv = 0, raux = 0, nvdone = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0]  rchan = 0, wstrb = 4'hF;
  logic [15:0] rraw = 0;
  logic [1:0]  resp;
  int          err_total = 0, tests_run = 0, nv_cnt = 0, n0, n1;
  wire         awrdy, wrdy, bvalid, arrdy, rvalid, sstart, resv, resaux, nvsave;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rd;
  wire [3:0]   mux, reschan;
  wire [15:0]  resdata;
  ////////////////////////////////////////////////////////////////////////////
  cacu_top #(.PARK_CYCLES(PARK)) u_dut (.CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .SAMPLE_REQ(req), .SAMPLE_DONE(done), .SAMPLE_START(sstart),
    .MUX_SEL(mux), .RAW_VALID(rawv), .RAW_IS_AUX(raux), .RAW_CHAN(rchan), .RAW_DATA(rraw),
    .RES_VALID(resv), .RES_IS_AUX(resaux), .RES_CHAN(reschan), .RES_DATA(resdata),
    .NV_SAVE(nvsave), .NV_DONE(nvdone));
  initial
  begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
    if (nvsave === 1'b1)
      nv_cnt++;
  ////////////////////////////////////////////////////////////////////////////
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1;
    wv <= 1;
    bready <= 1;
    do
    begin
      @(posedge clk);
      if (awrdy)
        awv <= 0;
      if (wrdy)
        wv <= 0;
    end
    while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arv <= 1;
    rready <= 1;
    do
    begin
      @(posedge clk);
      if (arrdy)
        arv <= 0;
    end
    while (rvalid !== 1'b1);
    rdata = rd;
    resp = rresp;
    rready <= 0;
  endtask
  task automatic res(input logic a, input logic [3:0] c, input logic [15:0] r, e);
    @(posedge clk);
    rawv <= 1;
    raux <= a;
    rchan <= c;
    rraw <= r;
    @(posedge clk);
    rawv <= 0;
    @(posedge clk);
    `CHK(resdata, e)
  endtask
  // Counts edges from request to start, then completes the sample
  task automatic smp(output int n);
    @(posedge clk);
    req <= 1;
    @(posedge clk);
    req <= 0;
    n = 0;
    while (sstart !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    done <= 1;
    @(posedge clk);
    done <= 0;
    repeat (2) @(posedge clk);
  endtask
  task automatic complete_run;
    if (err_total == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    `CHK(mux, 4'hF)
    axr(ADDR_CHAN_EN);
    `CHK(rdata, 32'h0000FFFF)
    axr(8'hFC);
    `CHK({resp, rdata}, {RESP_SLVERR, 32'h0})
    axw(8'hFC, 32'hFF);
    `CHK(resp, RESP_SLVERR)
    res(0, 4'h2, 16'h1234, 16'h1234);
    res(1, 4'h0, 16'h0ABC, 16'h0ABC);
    axw(ADDR_CELL_GAIN, 32'h7F);
    axw(ADDR_CELL_OFFSET, 32'h05);
    axr(ADDR_CELL_GAIN);
    `CHK(rdata, 32'h7F)
    // Low strobe byte off: the gain trim must not move
    wstrb <= 4'hE;
    axw(ADDR_CELL_GAIN, 32'h00);
    wstrb <= 4'hF;
    axr(ADDR_CELL_GAIN);
    `CHK(rdata, 32'h7F)
    res(0, 4'hF, 16'h8000, 16'h8044);
    res(0, 4'h0, 16'h4000, 16'h4024);
    res(1, 4'h1, 16'h0ABC, 16'h0ABC);
    axw(ADDR_CELL_GAIN, 32'h80);
    axw(ADDR_CELL_OFFSET, 32'h80);
    res(0, 4'h3, 16'hFFFF, 16'hFEFF);
    res(0, 4'h3, 16'h0010, 16'h0000);
    axw(ADDR_AUX_BASE + 8'h0C, 32'h0201);
    axw(ADDR_AUX_BASE + 8'h10, 32'h01FF);
    axr(ADDR_AUX_BASE + 8'h0C);
    `CHK(rdata, 32'h00000201)
    res(1, 4'h3, 16'h1000, 16'h0E01);
    res(1, 4'h4, 16'hFF00, 16'hFFFF);
    res(1, 4'h5, 16'h1000, 16'h1000);
    axw(ADDR_CHAN_EN, 32'h00F0);
    repeat (3) @(posedge clk);
    `CHK(mux, 4'h7)
    smp(n0);
    axw(ADDR_DEVICE_CONTROL_REG, 32'h1);
    smp(n1);
    `CHK(n1, n0)
    smp(n1);
    `CHK(n1, n0 + PARK)
    // Save without keys must be ignored
    axw(ADDR_DEVICE_CONTROL_REG, 32'h3);
    repeat (5) @(posedge clk);
    `CHK(nv_cnt, 0)
    axw(ADDR_KEY_ONE, {16'h0, KEY_ONE_VALUE});
    axw(ADDR_KEY_TWO, {16'h0, KEY_TWO_VALUE});
    axw(ADDR_DEVICE_CONTROL_REG, 32'h3);
    repeat (5) @(posedge clk);
    `CHK(nv_cnt, 1)
    // Status: parking active, save busy, mux on channel 7
    axr(ADDR_STATUS);
    `CHK(rdata, 32'h00000073)
    nvdone <= 1;
    @(posedge clk);
    nvdone <= 0;
    axr(ADDR_STATUS);
    `CHK(rdata, 32'h00000071)
    complete_run;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    complete_run;
  end
endmodule
bind cacu_top cacu_props u_props (.CLK(CLK), .RST_N(RST_N), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .RAW_VALID(RAW_VALID), .RAW_IS_AUX(RAW_IS_AUX), .RAW_CHAN(RAW_CHAN),
  .RES_VALID(RES_VALID), .RES_IS_AUX(RES_IS_AUX), .RES_CHAN(RES_CHAN),
  .SAMPLE_START(SAMPLE_START), .NV_SAVE(NV_SAVE));
